// [logic/jdss_consts.vh]
// Constants shared by the jog and driving set sequencer.
`ifndef JDSS_CONSTS_VH
`define JDSS_CONSTS_VH
`define JDSS_QUICK_JOG_RESET 32'h000003e8
`define JDSS_SLOW_JOG_RESET 32'h000001f4
`define JDSS_SET_COUNT 16
`define JDSS_MODE_ABS 2'h0
`define JDSS_MODE_REL 2'h1
`define JDSS_MODE_SPEED 2'h2
`define JDSS_COND_SWITCH 2'h0
`define JDSS_COND_DELAY 2'h1
`define JDSS_COND_SW_DELAY 2'h2
`define JDSS_COND_FLYING 2'h3
`define JDSS_FOLLOW_NONE 5'h1f
`define JDSS_MOTION_STOP 2'h0
`define JDSS_MOTION_CREEP 2'h1
`define JDSS_MOTION_RAPID 2'h2
`define JDSS_MOTION_TARGET 2'h3
`endif

// [logic/jdss_jog_ctrl.v]
// Jog state machine: direction latch, creep and rapid speed selection.
`timescale 1ns/1ps
`default_nettype none
`include "jdss_consts.vh"
module jdss_jog_ctrl (
  input wire core_clk_i, // System clock.
  input wire reset_n_i, // Synchronous reset, active low.
  input wire allow_i, // Jog may start (positioning, enabled, standstill).
  input wire jog_positive_input_i, // Positive jog input.
  input wire jog_negative_input_i, // Negative jog input.
  output reg [1:0] jog_state_o, // Stop, creep or rapid.
  output reg jog_dir_neg_o // Direction of travel, 1 is negative.
);
  localparam [1:0] ST_STOP = 2'h0;
  localparam [1:0] ST_CREEP = 2'h1;
  localparam [1:0] ST_RAPID = 2'h2;
  reg first_now;
  reg second_now;
  reg second_prev_reg;
  reg pos_prev_reg;
  reg neg_prev_reg;
  reg pos_rise;
  reg neg_rise;
  always @* begin
    first_now = jog_dir_neg_o ? jog_negative_input_i : jog_positive_input_i;
    second_now = jog_dir_neg_o ? jog_positive_input_i : jog_negative_input_i;
    pos_rise = jog_positive_input_i & ~pos_prev_reg;
    neg_rise = jog_negative_input_i & ~neg_prev_reg;
  end
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      jog_state_o <= ST_STOP;
      jog_dir_neg_o <= 1'b0;
      second_prev_reg <= 1'b0;
      pos_prev_reg <= 1'b0;
      neg_prev_reg <= 1'b0;
    end else begin
      second_prev_reg <= second_now;
      pos_prev_reg <= jog_positive_input_i;
      neg_prev_reg <= jog_negative_input_i;
      case (jog_state_o)
        ST_STOP: begin
          // Only a fresh rise starts, so an input still held after a stop cannot restart.
          if (allow_i && (pos_rise ^ neg_rise)
              && (jog_positive_input_i ^ jog_negative_input_i)) begin
            jog_state_o <= ST_CREEP;
            jog_dir_neg_o <= jog_negative_input_i;
          end else if (allow_i && pos_rise && !neg_rise && !jog_dir_neg_o) begin
            jog_state_o <= ST_CREEP;
          end else if (allow_i && neg_rise && !pos_rise && jog_dir_neg_o) begin
            jog_state_o <= ST_CREEP;
          end
        end
        ST_CREEP: begin
          if (!first_now) begin
            jog_state_o <= ST_STOP;
          end else if (second_now && !second_prev_reg) begin
            jog_state_o <= ST_RAPID;
          end
        end
        ST_RAPID: begin
          if (!first_now) begin
            jog_state_o <= ST_STOP;
          end else if (!second_now) begin
            jog_state_o <= ST_CREEP;
          end
        end
        default: begin
          jog_state_o <= ST_STOP;
        end
      endcase
    end
  end
endmodule // jdss_jog_ctrl
`default_nettype wire

// [logic/jdss_sequencer.v]
// Jog and driving set sequencer top level.
`timescale 1ns/1ps
`default_nettype none
`include "jdss_consts.vh"
// Behaviour
// - Jog only in positioning control; jogging runs endless speed motion.
// - Jog request ignored unless axis stands still.
// - Two 32-bit jog speeds, quick default 1000, slow default 500.
// - First jog input from standstill moves at creep speed.
// - Second input during creep switches to rapid speed.
// - Releasing first input during rapid stops the axis.
// - Re-asserting first input resumes creep; rapid needs a fresh second edge.
// - Sixteen stored driving sets with position, mode, speeds, ramps, repeats, follow-up.
// - One jerk slip time in ms applies to all sets.
// - Active set number readable and driven binary on outputs when enabled.
// - Select bits form binary index, bit0 weight 1 to bit3 weight 8.
// - A set starts on release input, bus perform bit, or next start with nothing pending.
// - Releasing a new set aborts motion and follow-up sequence.
// - Next start runs pending repeat or follow-up under start condition 0 or 2; with nothing pending it acts as release.
// - Selection value 0 to 15 reset 0, plus read-only active set.
// - Feed hold pauses set motion (not jog) with programmed or quick-stop ramp, then resumes.
// - Run set, then repetitions of relative sets, then follow-up set.
// - Repeats and follow-ups use the same start-condition logic.
// - Any set activation restarts sequencing from the new set.
// - Mode 0 absolute, 1 relative, 2 endless speed ignoring target.
// - Follow-up -1 means none; 0 to 15 names next set.
// - Start condition 0 switch, 1 delay, 2 switch or delay, 3 flying.
// - Repetition count 0 to 255; repetitions served before follow-up.
module jdss_sequencer #(
  parameter SETS = `JDSS_SET_COUNT, // Number of driving sets.
  parameter DELAY_W = 16 // Width of the start delay in cycles.
) (
  input wire core_clk_i, // System clock, 100 MHz.
  input wire reset_n_i, // Synchronous reset, active low.
  input wire positioning_mode_i, // Axis is in positioning control.
  input wire control_enable_i, // Drive control enabled.
  input wire axis_standstill_i, // Axis at standstill.
  input wire target_reached_i, // Current positioning reached target.
  input wire jog_positive_input_i, // Positive jog input.
  input wire jog_negative_input_i, // Negative jog input.
  input wire [31:0] quick_jog_speed_i, // Quick jog speed written by software.
  input wire quick_jog_we_i, // Write strobe for quick jog speed.
  input wire [31:0] slow_jog_speed_i, // Slow jog speed written by software.
  input wire slow_jog_we_i, // Write strobe for slow jog speed.
  input wire [3:0] set_select_weight_input_i, // Select inputs, bit0 to bit3.
  input wire [3:0] select_assigned_i, // Which select weights have an input.
  input wire set_release_input_i, // Release terminal.
  input wire bus_perform_task_i, // Field bus perform driving task bit.
  input wire next_start_input_i, // Next start terminal.
  input wire bus_next_start_i, // Field bus repetition or follow-up bit.
  input wire feed_hold_i, // Feed hold, active high pauses motion.
  input wire hold_quick_stop_i, // Hold uses quick-stop ramp when high.
  input wire active_out_enable_i, // Drive active set on digital outputs.
  input wire [15:0] slip_time_ms_i, // Jerk slip time for all sets.
  input wire tbl_we_i, // Driving set table write strobe.
  input wire [3:0] tbl_idx_i, // Set written.
  input wire [31:0] tbl_pos_i, // Target position.
  input wire [1:0] tbl_mode_i, // Positioning mode.
  input wire [31:0] tbl_vel_i, // Velocity.
  input wire [31:0] tbl_acc_i, // Start-up acceleration.
  input wire [31:0] tbl_dec_i, // Braking deceleration.
  input wire [7:0] tbl_rep_i, // Repetition count.
  input wire [4:0] tbl_follow_i, // Follow-up set, 5'h1f means none.
  input wire [1:0] tbl_cond_i, // Start condition.
  input wire [DELAY_W-1:0] tbl_delay_i, // Start delay in cycles.
  output reg [1:0] motion_cmd_o, // Stop, creep, rapid or target motion.
  output reg motion_endless_o, // Motion is speed controlled, no target.
  output reg motion_start_o, // One-cycle pulse: new motion task begins.
  output reg motion_dir_neg_o, // Jog direction, 1 is negative.
  output reg [31:0] motion_speed_o, // Commanded speed.
  output reg [31:0] motion_pos_o, // Target position of active set.
  output reg [31:0] motion_acc_o, // Start-up acceleration of active set.
  output reg [31:0] motion_dec_o, // Braking deceleration of active set.
  output reg motion_relative_o, // Active set is relative.
  output reg motion_hold_o, // Motion paused by feed hold.
  output reg motion_quick_stop_o, // Pause uses quick-stop ramp.
  output reg [15:0] slip_time_ms_o, // Jerk slip time applied to all sets.
  output reg [31:0] quick_jog_speed_o, // Stored quick jog speed.
  output reg [31:0] slow_jog_speed_o, // Stored slow jog speed.
  output reg [3:0] set_select_index_o, // Selection mirrored from inputs.
  output reg [3:0] active_set_indication_o, // Set being processed.
  output reg [3:0] active_set_pins_o, // Active set on digital outputs.
  output reg [7:0] repeats_left_o, // Repetitions still pending.
  output reg seq_busy_o // Repeat or follow-up pending.
);
  localparam [1:0] SQ_IDLE = 2'h0;
  localparam [1:0] SQ_RUN = 2'h1;
  localparam [1:0] SQ_WAIT = 2'h2;
  reg [31:0] pos_mem [0:SETS-1];
  reg [1:0] mode_mem [0:SETS-1];
  reg [31:0] vel_mem [0:SETS-1];
  reg [31:0] acc_mem [0:SETS-1];
  reg [31:0] dec_mem [0:SETS-1];
  reg [7:0] rep_mem [0:SETS-1];
  reg [4:0] fol_mem [0:SETS-1];
  reg [1:0] cond_mem [0:SETS-1];
  reg [DELAY_W-1:0] dly_mem [0:SETS-1];
  reg [1:0] seq_state_reg;
  reg [DELAY_W-1:0] delay_cnt_reg;
  reg release_prev_reg;
  reg next_prev_reg;
  reg started_reg;
  wire [1:0] jog_state;
  wire jog_dir_neg;
  wire [3:0] sel_idx;
  wire release_edge;
  wire next_edge;
  wire jog_allow;
  wire jogging;
  wire [3:0] cur;
  wire cur_rel;
  wire [4:0] cur_fol;
  wire pending;
  wire cond_switch_ok;
  wire cond_delay_ok;
  wire advance;
  wire [3:0] adv_set;
  wire repeat_due;
  integer i;

  // A repetition is owed only by a relative set that still has repeats left.
  function repeat_owed(
    input [1:0] mode,
    input [7:0] left
  );
    repeat_owed = (mode == `JDSS_MODE_REL) && (left != 8'h00);
  endfunction

  assign sel_idx = set_select_weight_input_i & select_assigned_i;
  assign release_edge = (set_release_input_i | bus_perform_task_i) & ~release_prev_reg;
  assign next_edge = (next_start_input_i | bus_next_start_i) & ~next_prev_reg;
  assign jog_allow = positioning_mode_i & control_enable_i & axis_standstill_i
    & (motion_cmd_o != `JDSS_MOTION_TARGET);
  assign jogging = (jog_state != `JDSS_MOTION_STOP);
  assign cur = active_set_indication_o;
  assign cur_rel = (mode_mem[cur] == `JDSS_MODE_REL);
  assign cur_fol = fol_mem[cur];
  assign pending = (seq_state_reg == SQ_WAIT);
  // Repeats are only meaningful for relative sets and always precede follow-up.
  assign repeat_due = repeat_owed(mode_mem[cur], repeats_left_o);
  assign adv_set = repeat_due ? cur : cur_fol[3:0];
  assign cond_switch_ok = next_edge && (cond_mem[cur] == `JDSS_COND_SWITCH
    || cond_mem[cur] == `JDSS_COND_SW_DELAY);
  assign cond_delay_ok = (delay_cnt_reg == {DELAY_W{1'b0}}) && (cond_mem[cur] == `JDSS_COND_DELAY
    || cond_mem[cur] == `JDSS_COND_SW_DELAY || cond_mem[cur] == `JDSS_COND_FLYING);
  assign advance = pending && (cond_switch_ok || cond_delay_ok);

  jdss_jog_ctrl u_jog (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .allow_i(jog_allow),
    .jog_positive_input_i(jog_positive_input_i),
    .jog_negative_input_i(jog_negative_input_i),
    .jog_state_o(jog_state),
    .jog_dir_neg_o(jog_dir_neg)
  );

  // Table storage; written only through the table port.
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      for (i = 0; i < SETS; i = i + 1) begin
        pos_mem[i] <= 32'h00000000;
        mode_mem[i] <= `JDSS_MODE_REL;
        vel_mem[i] <= 32'h000003e8;
        acc_mem[i] <= 32'h00002710;
        dec_mem[i] <= 32'h00002710;
        rep_mem[i] <= 8'h00;
        fol_mem[i] <= `JDSS_FOLLOW_NONE;
        cond_mem[i] <= `JDSS_COND_SWITCH;
        dly_mem[i] <= {DELAY_W{1'b0}};
      end
    end else if (tbl_we_i) begin
      pos_mem[tbl_idx_i] <= tbl_pos_i;
      mode_mem[tbl_idx_i] <= tbl_mode_i;
      vel_mem[tbl_idx_i] <= tbl_vel_i;
      acc_mem[tbl_idx_i] <= tbl_acc_i;
      dec_mem[tbl_idx_i] <= tbl_dec_i;
      rep_mem[tbl_idx_i] <= tbl_rep_i;
      // Values 16 to 30 are not valid set numbers and are kept as none.
      fol_mem[tbl_idx_i] <= tbl_follow_i[4] ? `JDSS_FOLLOW_NONE : tbl_follow_i;
      cond_mem[tbl_idx_i] <= tbl_cond_i;
      dly_mem[tbl_idx_i] <= tbl_delay_i;
    end
  end

  // Set sequencing.
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      seq_state_reg <= SQ_IDLE;
      delay_cnt_reg <= {DELAY_W{1'b0}};
      release_prev_reg <= 1'b0;
      next_prev_reg <= 1'b0;
      started_reg <= 1'b0;
      active_set_indication_o <= 4'h0;
      repeats_left_o <= 8'h00;
      set_select_index_o <= 4'h0;
      seq_busy_o <= 1'b0;
    end else begin
      release_prev_reg <= set_release_input_i | bus_perform_task_i;
      next_prev_reg <= next_start_input_i | bus_next_start_i;
      set_select_index_o <= sel_idx;
      started_reg <= 1'b0;
      if (jogging) begin
        seq_state_reg <= SQ_IDLE;
      end else if (positioning_mode_i && control_enable_i
          && (release_edge || (next_edge && !pending))) begin
        // New activation discards whatever sequence was running.
        active_set_indication_o <= sel_idx;
        repeats_left_o <= rep_mem[sel_idx];
        seq_state_reg <= SQ_RUN;
        started_reg <= 1'b1;
      end else if (advance) begin
        active_set_indication_o <= adv_set;
        if (repeat_due) begin
          repeats_left_o <= repeats_left_o - 8'h01;
        end else begin
          repeats_left_o <= rep_mem[adv_set];
        end
        seq_state_reg <= SQ_RUN;
        started_reg <= 1'b1;
      end else begin
        case (seq_state_reg)
          SQ_RUN: begin
            // Flying transition loads no delay, so it moves on one cycle in SQ_WAIT after the target is reached.
            // The cycle after a start is skipped so a late reached pulse of the old task is dropped.
            if (target_reached_i && !started_reg && mode_mem[cur] != `JDSS_MODE_SPEED) begin
              if (repeat_due || !cur_fol[4]) begin
                seq_state_reg <= SQ_WAIT;
                delay_cnt_reg <= (cond_mem[cur] == `JDSS_COND_FLYING) ? {DELAY_W{1'b0}}
                  : dly_mem[cur];
              end else begin
                seq_state_reg <= SQ_IDLE;
              end
            end
          end
          SQ_WAIT: begin
            if (delay_cnt_reg != {DELAY_W{1'b0}}) begin
              delay_cnt_reg <= delay_cnt_reg - {{(DELAY_W-1){1'b0}}, 1'b1};
            end
          end
          default: begin
            seq_state_reg <= SQ_IDLE;
          end
        endcase
      end
      seq_busy_o <= pending;
    end
  end

  // Motion command outputs.
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      motion_cmd_o <= `JDSS_MOTION_STOP;
      motion_endless_o <= 1'b0;
      motion_start_o <= 1'b0;
      motion_dir_neg_o <= 1'b0;
      motion_speed_o <= 32'h00000000;
      motion_pos_o <= 32'h00000000;
      motion_acc_o <= 32'h00000000;
      motion_dec_o <= 32'h00000000;
      motion_relative_o <= 1'b0;
      motion_hold_o <= 1'b0;
      motion_quick_stop_o <= 1'b0;
      slip_time_ms_o <= 16'h0000;
      quick_jog_speed_o <= `JDSS_QUICK_JOG_RESET;
      slow_jog_speed_o <= `JDSS_SLOW_JOG_RESET;
      active_set_pins_o <= 4'h0;
    end else begin
      if (quick_jog_we_i) begin
        quick_jog_speed_o <= quick_jog_speed_i;
      end
      if (slow_jog_we_i) begin
        slow_jog_speed_o <= slow_jog_speed_i;
      end
      slip_time_ms_o <= slip_time_ms_i;
      motion_hold_o <= feed_hold_i && (seq_state_reg == SQ_RUN);
      motion_quick_stop_o <= hold_quick_stop_i;
      active_set_pins_o <= active_out_enable_i ? active_set_indication_o : 4'h0;
      motion_start_o <= started_reg;
      motion_dir_neg_o <= jog_dir_neg;
      motion_pos_o <= pos_mem[cur];
      motion_acc_o <= acc_mem[cur];
      motion_dec_o <= dec_mem[cur];
      motion_relative_o <= cur_rel;
      if (jogging) begin
        motion_cmd_o <= jog_state;
        motion_endless_o <= 1'b1;
        motion_speed_o <= (jog_state == `JDSS_MOTION_RAPID) ? quick_jog_speed_o
          : slow_jog_speed_o;
      end else if (seq_state_reg == SQ_RUN) begin
        motion_cmd_o <= `JDSS_MOTION_TARGET;
        motion_endless_o <= (mode_mem[cur] == `JDSS_MODE_SPEED);
        motion_speed_o <= vel_mem[cur];
      end else begin
        motion_cmd_o <= `JDSS_MOTION_STOP;
        motion_endless_o <= 1'b0;
        motion_speed_o <= 32'h00000000;
      end
    end
  end
endmodule // jdss_sequencer
`default_nettype wire

// [dv/jdss_seq_assertions.sv]
// Port checks for the jog and driving set sequencer.
`timescale 1ns/1ps
`default_nettype none
module jdss_seq_assertions (
  input wire logic core_clk_i, // Clock.
  input wire logic reset_n_i, // Reset, active low.
  input wire logic positioning_mode_i, // Positioning.
  input wire logic control_enable_i, // Enabled.
  input wire logic axis_standstill_i, // At rest.
  input wire logic jog_positive_input_i, // Jog plus.
  input wire logic jog_negative_input_i, // Jog minus.
  input wire logic [3:0] set_select_weight_input_i, // Select.
  input wire logic [3:0] select_assigned_i, // Assigned.
  input wire logic set_release_input_i, // Release.
  input wire logic bus_perform_task_i, // Bus release.
  input wire logic [1:0] motion_cmd_o, // Command.
  input wire logic motion_endless_o, // Endless.
  input wire logic motion_start_o, // Start.
  input wire logic motion_dir_neg_o, // Direction.
  input wire logic [31:0] motion_speed_o, // Speed.
  input wire logic [31:0] slow_jog_speed_o, // Creep speed.
  input wire logic [3:0] set_select_index_o, // Selection.
  input wire logic [3:0] active_set_indication_o // Active set.
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic jogging = motion_cmd_o == 2'h1 || motion_cmd_o == 2'h2;
  wire logic relative_target_mode = set_release_input_i | bus_perform_task_i;
  wire logic ok = positioning_mode_i & control_enable_i;
  wire logic [3:0] sel = set_select_weight_input_i & select_assigned_i;
  creep_start_a: assert property (ok && axis_standstill_i && motion_cmd_o == 2'h0
    && $rose(jog_positive_input_i) && !jog_negative_input_i
    |-> ##[1:2] motion_cmd_o == 2'h1 && !motion_dir_neg_o) else $error("no creep start");
  rapid_switch_a: assert property (motion_cmd_o == 2'h1 && !motion_dir_neg_o
    && jog_positive_input_i && $rose(jog_negative_input_i)
    |-> ##[1:2] motion_cmd_o == 2'h2) else $error("no rapid");
  rapid_stop_a: assert property (motion_cmd_o == 2'h2 && (motion_dir_neg_o ?
    $fell(jog_negative_input_i) : $fell(jog_positive_input_i))
    |-> ##[1:2] motion_cmd_o == 2'h0) else $error("no stop");
  moving_refuse_a: assert property (motion_cmd_o == 2'h0 && !axis_standstill_i
    |=> !jogging) else $error("jog while moving");
  jog_endless_a: assert property (jogging |-> motion_endless_o) else $error("not endless");
  mode_refuse_a: assert property (!positioning_mode_i && !$past(positioning_mode_i)
    && motion_cmd_o == 2'h0 |=> !jogging) else $error("jog outside positioning");
  creep_speed_a: assert property (motion_cmd_o == 2'h1
    |-> motion_speed_o == slow_jog_speed_o) else $error("creep speed");
  release_start_a: assert property ($rose(relative_target_mode) && ok && !jogging
    |-> ##[1:3] motion_start_o) else $error("set not started");
  active_index_a: assert property ($rose(relative_target_mode) && ok && !jogging
    |=> active_set_indication_o == $past(sel)) else $error("active set");
  select_mirror_a: assert property ($past(reset_n_i)
    |-> set_select_index_o == $past(sel)) else $error("selection");
endmodule // jdss_seq_assertions
bind jdss_sequencer jdss_seq_assertions i_chk (.*);
`default_nettype wire

// [dv/jdss_ctrl_model.sv]
// Controller side model reporting axis rest and target reached.
`timescale 1ns/1ps
`default_nettype none
module jdss_ctrl_model (
  input wire logic core_clk_i, // Clock.
  input wire logic reset_n_i, // Reset, active low.
  input wire logic [1:0] cmd_i, // Motion command.
  input wire logic start_i, // Set motion start.
  input wire logic slow_i, // Long travel.
  output logic standstill_o, // Axis at rest.
  output logic reached_o // Target reached pulse.
);
  logic [5:0] travel_reg;
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      travel_reg <= 6'h00;
      standstill_o <= 1'b1;
      reached_o <= 1'b0;
    end else begin
      if (start_i) begin
        travel_reg <= slow_i ? 6'h28 : 6'h04;
      end else if (travel_reg != 6'h00) begin
        travel_reg <= travel_reg - 6'h01;
      end
      reached_o <= travel_reg == 6'h01 && !start_i;
      // Rest is reported a cycle after the stop, so the axis is seen moving meanwhile.
      standstill_o <= cmd_i != 2'h1 && cmd_i != 2'h2 && travel_reg == 6'h00 && !start_i;
    end
  end
endmodule // jdss_ctrl_model
`default_nettype wire

// [dv/jdss_sequencer_tb.sv]
// Self-checking bench for the jog and driving set sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "jdss_consts.vh"
module jdss_sequencer_tb;
  logic core_clk_i = 1'b0, reset_n_i = 1'b0, positioning_mode_i = 1'b1, control_enable_i = 1'b1;
  logic jog_positive_input_i = 1'b0, jog_negative_input_i = 1'b0, set_release_input_i = 1'b0;
  logic bus_perform_task_i = 1'b0, next_start_input_i = 1'b0, bus_next_start_i = 1'b0;
  logic feed_hold_i = 1'b0, hold_quick_stop_i = 1'b0, active_out_enable_i = 1'b0, slow = 1'b0;
  logic quick_jog_we_i = 1'b0, slow_jog_we_i = 1'b0, tbl_we_i = 1'b0;
  logic [31:0] quick_jog_speed_i = 32'h0, slow_jog_speed_i = 32'h0, tbl_pos_i = 32'h0;
  logic [31:0] tbl_vel_i = 32'h0, tbl_acc_i = 32'h64, tbl_dec_i = 32'hc8;
  logic [3:0] set_select_weight_input_i = 4'h0, select_assigned_i = 4'hf, tbl_idx_i = 4'h0;
  logic [1:0] tbl_mode_i = 2'h0, tbl_cond_i = 2'h0, motion_cmd_o;
  logic [7:0] tbl_rep_i = 8'h0, repeats_left_o;
  logic [4:0] tbl_follow_i = 5'h1f;
  logic [15:0] tbl_delay_i = 16'h2, slip_time_ms_i = 16'h7, slip_time_ms_o;
  logic motion_endless_o, motion_start_o, motion_dir_neg_o, motion_relative_o, motion_hold_o;
  logic motion_quick_stop_o, seq_busy_o, axis_standstill_i, target_reached_i;
  logic [31:0] motion_speed_o, motion_pos_o, motion_acc_o, motion_dec_o;
  logic [31:0] quick_jog_speed_o, slow_jog_speed_o;
  logic [3:0] set_select_index_o, active_set_indication_o, active_set_pins_o;
  // Row: plus, minus, expected command, expected direction.
  logic [4:0] rows [13] = '{5'h00, 5'h12, 5'h1c, 5'h08, 5'h1a, 5'h12, 5'h1c, 5'h12, 5'h00,
    5'h0b, 5'h1d, 5'h11, 5'h01};
  int fail_count = 0, n_compared = 0, n_starts = 0, cycles = 0;
  jdss_sequencer #(.SETS(16), .DELAY_W(16)) i_dut (.*);
  jdss_ctrl_model i_ctrl (.core_clk_i, .reset_n_i, .cmd_i(motion_cmd_o), .start_i(motion_start_o),
    .slow_i(slow), .standstill_o(axis_standstill_i), .reached_o(target_reached_i));
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic print_verdict();
    $display("compared %0d, wrong %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cycles++;
    if (motion_start_o === 1'b1) n_starts++;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wset(input logic [3:0] i, input logic [1:0] m, input logic [7:0] r,
    input logic [4:0] f, input logic [1:0] c, input logic [31:0] v);
    {tbl_idx_i, tbl_mode_i, tbl_rep_i, tbl_follow_i, tbl_cond_i, tbl_vel_i} = {i, m, r, f, c, v};
    tbl_pos_i = {28'h0, i};
    tbl_we_i = 1'b1;
    tick(1);
    tbl_we_i = 1'b0;
    tick(1);
  endtask
  // Source 0 release pin, 1 bus release, 2 next pin, 3 bus next.
  task automatic go(input logic [3:0] idx, input logic [1:0] src);
    set_select_weight_input_i = idx;
    tick(1);
    {set_release_input_i, bus_perform_task_i, next_start_input_i, bus_next_start_i} = 4'h8 >> src;
    tick(1);
    {set_release_input_i, bus_perform_task_i, next_start_input_i, bus_next_start_i} = 4'h0;
  endtask
  task automatic wact(input logic [3:0] idx);
    int k;
    k = 0;
    while (active_set_indication_o !== idx && k < 300) begin
      tick(1);
      k++;
    end
    chk(active_set_indication_o, idx, "active set");
  endtask
  initial begin
    tick(12);
    reset_n_i = 1'b1;
    tick(2);
    chk(quick_jog_speed_o, 32'h3e8, "quick default");
    chk(slow_jog_speed_o, 32'h1f4, "slow default");
    chk(active_set_indication_o, 32'h0, "active after reset");
    chk(slip_time_ms_o, 32'h7, "slip time");
    {quick_jog_speed_i, slow_jog_speed_i} = {32'hffffffff, 32'h7};
    {quick_jog_we_i, slow_jog_we_i} = 2'h3;
    tick(1);
    {quick_jog_we_i, slow_jog_we_i} = 2'h0;
    tick(1);
    chk(quick_jog_speed_o, 32'hffffffff, "quick stored");
    foreach (rows[i]) begin
      {jog_positive_input_i, jog_negative_input_i} = rows[i][4:3];
      tick(4);
      chk(motion_cmd_o, rows[i][2:1], "jog state");
      if (rows[i][2:1] != 2'h0) begin
        chk(motion_dir_neg_o, rows[i][0], "jog direction");
        chk(motion_speed_o, rows[i][1] ? 32'h7 : 32'hffffffff, "jog speed");
        chk(motion_endless_o, 1'b1, "jog endless");
      end
    end
    {positioning_mode_i, jog_positive_input_i} = 2'h1;
    tick(4);
    chk(motion_cmd_o, 2'h0, "jog outside positioning");
    {positioning_mode_i, jog_positive_input_i} = 2'h2;
    tick(2);
    wset(4'h5, `JDSS_MODE_REL, 8'h01, 5'h09, `JDSS_COND_DELAY, 32'h123);
    wset(4'h9, `JDSS_MODE_ABS, 8'h00, `JDSS_FOLLOW_NONE, `JDSS_COND_SWITCH, 32'h456);
    wset(4'h2, `JDSS_MODE_SPEED, 8'h00, `JDSS_FOLLOW_NONE, `JDSS_COND_SWITCH, 32'h789);
    n_starts = 0;
    go(4'h5, 2'd0);
    wact(4'h5);
    tick(2);
    chk(motion_cmd_o, 2'h3, "set motion");
    chk(motion_speed_o, 32'h123, "set speed");
    chk(motion_acc_o, 32'h64, "set acceleration");
    chk(motion_dec_o, 32'hc8, "set deceleration");
    chk(motion_relative_o, 1'b1, "relative mode");
    chk(repeats_left_o, 8'h01, "repeats pending");
    wact(4'h9);
    tick(3);
    chk(n_starts, 32'h3, "set, repeat, follow-up");
    chk(motion_pos_o, 32'h9, "absolute target");
    tick(8);
    chk(seq_busy_o, 1'b0, "no follow-up");
    for (int c = 0; c < 4; c++) begin
      wset(4'ha + c[3:0], `JDSS_MODE_REL, 8'h00, 5'h09, c[1:0], 32'h100);
      go(4'ha + c[3:0], 2'd1);
      tick(12);
      if (c == 0) begin
        chk(seq_busy_o, 1'b1, "waits for next start");
        go(4'h0, 2'd3);
      end
      wact(4'h9);
      tick(8);
    end
    go(4'h3, 2'd2);
    wact(4'h3);
    slow = 1'b1;
    go(4'h5, 2'd1);
    tick(4);
    jog_positive_input_i = 1'b1;
    tick(3);
    chk(motion_cmd_o, 2'h3, "no jog during set");
    jog_positive_input_i = 1'b0;
    go(4'h2, 2'd0);
    wact(4'h2);
    tick(3);
    chk(repeats_left_o, 8'h00, "sequence dropped");
    chk(motion_endless_o, 1'b1, "speed mode");
    chk(motion_speed_o, 32'h789, "speed mode velocity");
    {feed_hold_i, hold_quick_stop_i} = 2'h3;
    tick(3);
    chk({motion_hold_o, motion_quick_stop_o}, 2'h3, "hold with quick stop");
    feed_hold_i = 1'b0;
    tick(3);
    chk(motion_hold_o, 1'b0, "resume");
    active_out_enable_i = 1'b1;
    tick(3);
    chk(active_set_pins_o, 4'h2, "active pins");
    active_out_enable_i = 1'b0;
    tick(3);
    chk(active_set_pins_o, 4'h0, "pins off");
    {select_assigned_i, set_select_weight_input_i} = 8'h5f;
    tick(3);
    chk(set_select_index_o, 4'h5, "masked selection");
    print_verdict();
  end
endmodule // jdss_sequencer_tb
`default_nettype wire
